//--- verilog/pcpa_pkg.sv
package pcpa_pkg;
   // ***************************************************
   // Register map (byte addresses)
   // ***************************************************
   localparam logic [11:0] PAD_CONFIG_OFS = 12'hF3C;
   localparam logic [11:0] SPI_OD_OFS = 12'hF40;
   localparam logic [11:0] SERIAL_OD_OFS = 12'hF41;
   localparam logic [11:0] CPWM_OD_OFS = 12'hF42;
   localparam logic [11:0] PIN_DATA_A_DATA_OFS = 12'hF80;
   localparam logic [11:0] PIN_DATA_A_LATCH_OFS = 12'hF84;
   localparam logic [11:0] PIN_DATA_A_DIR_OFS = 12'hF88;
   localparam logic [11:0] ANALOG_CFG0_OFS = 12'hF8C;
   localparam logic [11:0] ANALOG_CTL_OFS = 12'hF90;
   localparam logic [11:0] CLOCK_PIN_OFS = 12'hF94;
   // ***************************************************
   // Field positions and masks
   // ***************************************************
   localparam int TTL_BIT = 0;
   localparam int CLK_SEL_LSB = 1;
   localparam logic [7:0] OD_MASK = 8'h03;
   localparam logic [7:0] PAD_MASK = 8'h07;
   localparam logic [7:0] PIN_DATA_A_MASK = 8'hEF;
   localparam logic [7:0] ANALOG_CAP_MASK = 8'h2F;
   localparam logic [7:0] ANALOG_CTL_MASK = 8'h07;
   localparam int COMPARATOR_REF_OUTPUT_OE_BIT = 0;
   localparam int CMP1_SEL_BIT = 1;
   localparam int CMP2_SEL_BIT = 2;
   localparam int COMPARATOR_REF_OUTPUT_PIN = 2;
   localparam int CLK_OE_BIT = 0;
   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hEF;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [1:0] {
      CLK_SEL_ALARM = 2'h0,
      CLK_SEL_SECONDS = 2'h1,
      CLK_SEL_SOURCE = 2'h2,
      CLK_SEL_RSVD = 2'h3
   } pcpa_clk_sel_t;
   typedef enum logic [1:0] {
      OSC_NONE,
      OSC_CLKOUT,
      OSC_CRYSTAL
   } pcpa_osc_mode_t;
   typedef struct packed {
      logic [1:0] cpwm;
      logic [1:0] serial;
      logic [1:0] spi;
   } pcpa_od_t;
endpackage

//--- verilog/pcpa_top.sv
// Added by the designer: the Avalon-MM register port.
module pcpa_top (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic ARST_N_I,
   // Avalon-MM slave
   input wire logic [11:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // Oscillator mode
   input wire pcpa_pkg::pcpa_osc_mode_t OSC_MODE_I,
   // Port A pins
   input wire logic [7:0] PIN_DATA_A_PIN_I,
   output logic [7:0] PIN_DATA_A_PIN_O,
   output logic [7:0] PIN_DATA_A_PIN_OE_O,
   // Peripheral outputs (bit0 clock, bit1 data per module)
   input wire logic [1:0] CPWM_OUT_I [2],
   input wire logic [1:0] SERIAL_OUT_I [2],
   input wire logic [1:0] SPI_OUT_I [2],
   output logic [1:0] PERIPH_PIN_O [6],
   output logic [1:0] PERIPH_PIN_OE_O [6],
   // Real-time clock sources and pin
   input wire logic CLK_ALARM_I,
   input wire logic CLK_SECONDS_I,
   input wire logic CLK_SOURCE_I,
   output logic CLK_PIN_O,
   output logic CLK_PIN_OE_O,
   // Pad controls and comparator inputs
   output logic PARALLEL_PORT_TTL_SELECT_O,
   output logic [1:0] CMP1_IN_O,
   output logic [1:0] CMP2_IN_O
);
   // ***************************************************
   // Registers
   // ***************************************************
   pcpa_pkg::pcpa_od_t od_q;
   logic [7:0] pad_q;
   logic [7:0] lat_q;
   logic [7:0] dir_q;
   logic [7:0] acfg_q;
   logic [7:0] actl_q;
   logic clk_oe_q;
   logic [7:0] pin_s1_q;
   logic [7:0] pin_s2_q;
   logic ack_q;
   logic [7:0] mask_d;
   logic [7:0] din_d;
   logic [7:0] rd_d;

   function automatic logic [7:0] wr_val(input logic [7:0] old, input logic [7:0] msk);
      wr_val = AVS_BYTEENABLE_I[0] ? (AVS_WRITEDATA_I[7:0] & msk) : old;
   endfunction

   wire wr_go = AVS_WRITE_I && !ack_q;
   wire [7:0] wd = AVS_WRITEDATA_I[7:0];

   // ***************************************************
   // Bus handshake: answer one cycle after request
   // ***************************************************
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ack_q <= 1'b0;
         AVS_WAITREQUEST_O <= 1'b1;
      end else begin
         ack_q <= (AVS_READ_I || AVS_WRITE_I) && !ack_q;
         AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && !ack_q);
      end
   end

   // ***************************************************
   // Pin synchroniser
   // ***************************************************
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pin_s1_q <= pcpa_pkg::REG_RST;
         pin_s2_q <= pcpa_pkg::REG_RST;
      end else begin
         pin_s1_q <= PIN_DATA_A_PIN_I;
         pin_s2_q <= pin_s1_q;
      end
   end

   // ***************************************************
   // Configuration registers
   // ***************************************************
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         od_q <= '0;
         pad_q <= pcpa_pkg::REG_RST;
      end else if (wr_go && AVS_BYTEENABLE_I[0]) begin
         unique case (AVS_ADDRESS_I)
            pcpa_pkg::CPWM_OD_OFS: od_q.cpwm <= wd[1:0];
            pcpa_pkg::SERIAL_OD_OFS: od_q.serial <= wd[1:0];
            pcpa_pkg::SPI_OD_OFS: od_q.spi <= wd[1:0];
            pcpa_pkg::PAD_CONFIG_OFS: pad_q <= wd & pcpa_pkg::PAD_MASK;
            default: ;
         endcase
      end
   end

   // ***************************************************
   // Port A, analog and clock pin registers
   // ***************************************************
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         lat_q <= pcpa_pkg::REG_RST;
         dir_q <= pcpa_pkg::DIR_RST;
         acfg_q <= pcpa_pkg::REG_RST;
         actl_q <= pcpa_pkg::REG_RST;
         clk_oe_q <= 1'b0;
      end else if (wr_go) begin
         unique case (AVS_ADDRESS_I)
            pcpa_pkg::PIN_DATA_A_DATA_OFS,
            pcpa_pkg::PIN_DATA_A_LATCH_OFS: lat_q <= wr_val(lat_q, pcpa_pkg::PIN_DATA_A_MASK);
            pcpa_pkg::PIN_DATA_A_DIR_OFS: dir_q <= wr_val(dir_q, pcpa_pkg::PIN_DATA_A_MASK);
            pcpa_pkg::ANALOG_CFG0_OFS: acfg_q <= wr_val(acfg_q, 8'hFF);
            pcpa_pkg::ANALOG_CTL_OFS: actl_q <= wr_val(actl_q, pcpa_pkg::ANALOG_CTL_MASK);
            pcpa_pkg::CLOCK_PIN_OFS: begin
               if (AVS_BYTEENABLE_I[0]) begin
                  clk_oe_q <= wd[pcpa_pkg::CLK_OE_BIT];
               end
            end
            default: ;
         endcase
      end
   end

   // ***************************************************
   // Usable pins, digital input path
   // ***************************************************
   always_comb begin
      mask_d = pcpa_pkg::PIN_DATA_A_MASK;
      unique case (OSC_MODE_I)
         pcpa_pkg::OSC_CLKOUT: mask_d[6] = 1'b0;
         pcpa_pkg::OSC_CRYSTAL: mask_d[7:6] = 2'b00;
         default: ;
      endcase
      // Digital input gated by config on analog pins
      din_d = pin_s2_q & mask_d & (acfg_q | ~pcpa_pkg::ANALOG_CAP_MASK);
      if (actl_q[pcpa_pkg::COMPARATOR_REF_OUTPUT_OE_BIT]) begin
         din_d[pcpa_pkg::COMPARATOR_REF_OUTPUT_PIN] = 1'b0;
      end
   end

   // ***************************************************
   // Read mux
   // ***************************************************
   always_comb begin
      unique case (AVS_ADDRESS_I)
         pcpa_pkg::CPWM_OD_OFS: rd_d = {6'h00, od_q.cpwm};
         pcpa_pkg::SERIAL_OD_OFS: rd_d = {6'h00, od_q.serial};
         pcpa_pkg::SPI_OD_OFS: rd_d = {6'h00, od_q.spi};
         pcpa_pkg::PAD_CONFIG_OFS: rd_d = pad_q;
         pcpa_pkg::PIN_DATA_A_DATA_OFS: rd_d = din_d;
         pcpa_pkg::PIN_DATA_A_LATCH_OFS: rd_d = lat_q;
         pcpa_pkg::PIN_DATA_A_DIR_OFS: rd_d = dir_q;
         pcpa_pkg::ANALOG_CFG0_OFS: rd_d = acfg_q;
         pcpa_pkg::ANALOG_CTL_OFS: rd_d = actl_q;
         pcpa_pkg::CLOCK_PIN_OFS: rd_d = {7'h00, clk_oe_q};
         default: rd_d = pcpa_pkg::UNMAPPED_RD[7:0];
      endcase
   end

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         AVS_READDATA_O <= 32'h0000_0000;
      end else if (AVS_READ_I && !ack_q) begin
         AVS_READDATA_O <= {24'h00_0000, rd_d};
      end
   end

   // ***************************************************
   // Port A pin drive
   // ***************************************************
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         PIN_DATA_A_PIN_O <= 8'h00;
         PIN_DATA_A_PIN_OE_O <= 8'h00;
      end else begin
         PIN_DATA_A_PIN_O <= lat_q;
         PIN_DATA_A_PIN_OE_O <= ~dir_q & mask_d;
         if (actl_q[pcpa_pkg::COMPARATOR_REF_OUTPUT_OE_BIT]) begin
            PIN_DATA_A_PIN_OE_O[pcpa_pkg::COMPARATOR_REF_OUTPUT_PIN] <= 1'b0;
         end
      end
   end

   // ***************************************************
   // Comparator inputs from analog pins
   // ***************************************************
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         CMP1_IN_O <= 2'b00;
         CMP2_IN_O <= 2'b00;
      end else begin
         CMP1_IN_O <= (actl_q[pcpa_pkg::CMP1_SEL_BIT] && dir_q[0] && !acfg_q[0]) ?
                      {pin_s2_q[3], pin_s2_q[0]} : 2'b00;
         CMP2_IN_O <= (actl_q[pcpa_pkg::CMP2_SEL_BIT] && dir_q[1] && !acfg_q[1]) ?
                      {pin_s2_q[2], pin_s2_q[1]} : 2'b00;
      end
   end

   // ***************************************************
   // Peripheral open-drain pads (fixed pin per module output)
   // ***************************************************
   logic [1:0] od_en [6];
   logic [1:0] po [6];
   always_comb begin
      for (int m = 0; m < 2; m++) begin
         od_en[m] = {2{od_q.cpwm[m]}};
         od_en[m + 2] = {2{od_q.serial[m]}};
         od_en[m + 4] = {2{od_q.spi[m]}};
         po[m] = CPWM_OUT_I[m];
         po[m + 2] = SERIAL_OUT_I[m];
         po[m + 4] = SPI_OUT_I[m];
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         for (int k = 0; k < 6; k++) begin
            PERIPH_PIN_O[k] <= 2'b00;
            PERIPH_PIN_OE_O[k] <= 2'b00;
         end
      end else begin
         for (int k = 0; k < 6; k++) begin
            // Open-drain: drive low only, release for high; otherwise push-pull
            PERIPH_PIN_O[k] <= po[k] & ~od_en[k];
            PERIPH_PIN_OE_O[k] <= ~(od_en[k] & po[k]);
         end
      end
   end

   // ***************************************************
   // Clock pin and pad select
   // ***************************************************
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         CLK_PIN_O <= 1'b0;
         CLK_PIN_OE_O <= 1'b0;
         PARALLEL_PORT_TTL_SELECT_O <= 1'b0;
      end else begin
         unique case (pcpa_pkg::pcpa_clk_sel_t'(pad_q[pcpa_pkg::CLK_SEL_LSB +: 2]))
            pcpa_pkg::CLK_SEL_ALARM: CLK_PIN_O <= CLK_ALARM_I;
            pcpa_pkg::CLK_SEL_SECONDS: CLK_PIN_O <= CLK_SECONDS_I;
            pcpa_pkg::CLK_SEL_SOURCE: CLK_PIN_O <= CLK_SOURCE_I;
            pcpa_pkg::CLK_SEL_RSVD: CLK_PIN_O <= 1'b0;
         endcase
         CLK_PIN_OE_O <= clk_oe_q;
         PARALLEL_PORT_TTL_SELECT_O <= pad_q[pcpa_pkg::TTL_BIT];
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!ARST_N_I);

   od_low_only_a: assert property (
      od_q.spi[0] |=> !(PERIPH_PIN_OE_O[4][0] && PERIPH_PIN_O[4][0])
   ) else $error("open-drain drove high");
   od_push_pull_a: assert property (
      od_q.cpwm[0] == 1'b0 && $stable(od_q) |=> PERIPH_PIN_OE_O[0] == 2'b11
   ) else $error("push-pull not driving");
   ttl_follow_a: assert property (
      ##1 PARALLEL_PORT_TTL_SELECT_O == $past(pad_q[0])
   ) else $error("ttl select wrong");
   clk_oe_a: assert property (
      ##1 CLK_PIN_OE_O == $past(clk_oe_q)
   ) else $error("clock pin enable wrong");
   dir_drive_a: assert property (
      dir_q[0] |=> !PIN_DATA_A_PIN_OE_O[0]
   ) else $error("input pin driven");
   bit4_zero_a: assert property (
      lat_q[4] == 1'b0 && dir_q[4] == 1'b0 ##0 !PIN_DATA_A_PIN_OE_O[4]
   ) else $error("bit 4 implemented");
   analog_zero_a: assert property (
      !acfg_q[0] |-> din_d[0] == 1'b0
   ) else $error("analog pin read nonzero");
   comparator_ref_output_off_a: assert property (
      actl_q[0] |=> !PIN_DATA_A_PIN_OE_O[2]
   ) else $error("reference pin driven");
   od_upper_a: assert property (
      AVS_READ_I && AVS_ADDRESS_I == pcpa_pkg::SPI_OD_OFS && !ack_q
      |=> AVS_READDATA_O[7:2] == 6'h00
   ) else $error("upper bits nonzero");
   bus_answer_a: assert property (
      (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O
   ) else $error("no answer in one cycle");
   bus_idle_a: assert property (
      !AVS_READ_I && !AVS_WRITE_I |=> AVS_WAITREQUEST_O
   ) else $error("answer without request");
   pad_upper_a: assert property (
      AVS_READ_I && AVS_ADDRESS_I == pcpa_pkg::PAD_CONFIG_OFS && AVS_WAITREQUEST_O
      |=> AVS_READDATA_O[7:3] == 5'h00
   ) else $error("pad upper bits nonzero");
   lat_follow_a: assert property (
      ##1 PIN_DATA_A_PIN_O == $past(lat_q)
   ) else $error("pin output not from latch");
   clk_sel_a: assert property (
      pad_q[2:1] == 2'b01 |=> CLK_PIN_O == $past(CLK_SECONDS_I)
   ) else $error("seconds clock not routed");
   cmp_gate_a: assert property (
      !actl_q[pcpa_pkg::CMP1_SEL_BIT] |=> CMP1_IN_O == 2'b00
   ) else $error("comparator input not gated");
   osc_mask_a: assert property (
      OSC_MODE_I == pcpa_pkg::OSC_CRYSTAL |=> PIN_DATA_A_PIN_OE_O[7:6] == 2'b00
   ) else $error("oscillator pin driven");
   analog_in_a: assert property (
      !acfg_q[5] |-> din_d[5] == 1'b0
   ) else $error("analog pin input not gated");

   wr_lat_c: cover property (wr_go && AVS_ADDRESS_I == pcpa_pkg::PIN_DATA_A_DATA_OFS);
   od_on_c: cover property (od_q.serial[1] && PERIPH_PIN_OE_O[3] == 2'b00);
   clk_src_c: cover property (CLK_PIN_OE_O && pad_q[2:1] == 2'b10);
   rd_data_c: cover property (AVS_READ_I && AVS_ADDRESS_I == pcpa_pkg::PIN_DATA_A_DATA_OFS);
   comparator_ref_output_c: cover property (actl_q[pcpa_pkg::COMPARATOR_REF_OUTPUT_OE_BIT] && dir_q[2] == 1'b0);
endmodule

//--- dv/pcpa_pin_model.sv
module pcpa_pin_model (
   // Port A side
   input wire logic [7:0] pin_data_a_o_i,
   input wire logic [7:0] pin_data_a_oe_i,
   input wire logic [7:0] ext_i,
   output logic [7:0] pin_data_a_lvl_o,
   // Peripheral pins
   input wire logic [1:0] periph_o_i [6],
   input wire logic [1:0] periph_oe_i [6],
   output logic [1:0] periph_lvl_o [6]
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************
   // Pin resolution
   // ***************************************************
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_data_a_lvl_o[i] = pin_data_a_oe_i[i] ? pin_data_a_o_i[i] : ext_i[i];
      end
   end
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         for (int b = 0; b < 2; b++) begin
            periph_lvl_o[i][b] = periph_oe_i[i][b] ? periph_o_i[i][b] : 1'b1;
         end
      end
   end
endmodule

//--- dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] address = 12'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] readdata;
   logic waitreq;
   logic [7:0] ext = 8'hFF;
   logic [7:0] pa_o, pa_oe, pa_lvl;
   logic [1:0] cpwm [2] = '{2'h2, 2'h2};
   logic [1:0] ser [2] = '{2'h2, 2'h2};
   logic [1:0] spi [2] = '{2'h2, 2'h2};
   logic [1:0] pp_o [6];
   logic [1:0] pp_oe [6];
   logic [1:0] pp_lvl [6];
   logic [2:0] src = 3'h0;
   pcpa_pkg::pcpa_osc_mode_t osc = pcpa_pkg::OSC_NONE;
   logic clk_o, clk_oe, ttl;
   logic [1:0] cmp1, cmp2;
   int errors = 0;
   int n_tests = 0;
   always #4 sys_clk = ~sys_clk;
   pcpa_top dut (.SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(address),
      .AVS_READ_I(read), .AVS_WRITE_I(write), .AVS_WRITEDATA_I(writedata),
      .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(readdata), .AVS_WAITREQUEST_O(waitreq),
      .OSC_MODE_I(osc), .PIN_DATA_A_PIN_I(pa_lvl), .PIN_DATA_A_PIN_O(pa_o),
      .PIN_DATA_A_PIN_OE_O(pa_oe), .CPWM_OUT_I(cpwm), .SERIAL_OUT_I(ser), .SPI_OUT_I(spi),
      .PERIPH_PIN_O(pp_o), .PERIPH_PIN_OE_O(pp_oe), .CLK_ALARM_I(src[0]),
      .CLK_SECONDS_I(src[1]), .CLK_SOURCE_I(src[2]), .CLK_PIN_O(clk_o),
      .CLK_PIN_OE_O(clk_oe), .PARALLEL_PORT_TTL_SELECT_O(ttl), .CMP1_IN_O(cmp1),
      .CMP2_IN_O(cmp2));
   pcpa_pin_model far (.pin_data_a_o_i(pa_o), .pin_data_a_oe_i(pa_oe), .ext_i(ext),
      .pin_data_a_lvl_o(pa_lvl), .periph_o_i(pp_o), .periph_oe_i(pp_oe), .periph_lvl_o(pp_lvl));
   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic report_and_stop();
      if (errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ack();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      if (waitreq !== 1'b0) begin
         errors++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      address <= a;
      writedata <= {24'h0, d};
      write <= 1'b1;
      wait_ack();
      write <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      address <= a;
      read <= 1'b1;
      wait_ack();
      read <= 1'b0;
      chk(readdata, {24'h0, exp});
   endtask
   task automatic settle();
      repeat (5) @(posedge sys_clk);
   endtask
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset();
      rchk(pcpa_pkg::PAD_CONFIG_OFS, 8'h00);
      rchk(pcpa_pkg::PIN_DATA_A_DIR_OFS, 8'hEF);
      rchk(pcpa_pkg::PIN_DATA_A_DATA_OFS, 8'hC0);
      rchk(12'hF00, 8'h00);
   endtask
   task automatic t_open_drain();
      logic [11:0] ofs [3];
      ofs = '{pcpa_pkg::CPWM_OD_OFS, pcpa_pkg::SERIAL_OD_OFS, pcpa_pkg::SPI_OD_OFS};
      for (int k = 0; k < 3; k++) begin
         rchk(ofs[k], 8'h00);
         wr(ofs[k], 8'hFF);
         rchk(ofs[k], 8'h03);
      end
      settle();
      for (int i = 0; i < 6; i++) begin
         chk({30'h0, pp_o[i]}, 32'h0);
         chk({30'h0, pp_oe[i]}, 32'h1);
         chk({30'h0, pp_lvl[i]}, 32'h2);
      end
      for (int k = 0; k < 3; k++) begin
         wr(ofs[k], 8'h00);
      end
      settle();
      for (int i = 0; i < 6; i++) begin
         chk({30'h0, pp_oe[i], pp_o[i]}, 32'hE);
      end
   endtask
   task automatic t_clock_pad();
      logic [2:0] sel;
      wr(pcpa_pkg::CLOCK_PIN_OFS, 8'h01);
      for (int c = 0; c < 4; c++) begin
         for (int v = 0; v < 2; v++) begin
            sel = 3'(1 << c);
            @(posedge sys_clk);
            src <= (v == 1) ? sel : ~sel;
            wr(pcpa_pkg::PAD_CONFIG_OFS, 8'(c << 1));
            settle();
            chk({30'h0, clk_oe, clk_o}, {30'h0, 1'b1, (c < 3) ? 1'(v) : 1'b0});
         end
      end
      wr(pcpa_pkg::CLOCK_PIN_OFS, 8'h00);
      settle();
      chk({31'h0, clk_oe}, 32'h0);
      wr(pcpa_pkg::PAD_CONFIG_OFS, 8'hFF);
      rchk(pcpa_pkg::PAD_CONFIG_OFS, 8'h07);
      wr(pcpa_pkg::PAD_CONFIG_OFS, 8'h01);
      be <= 4'h0;
      wr(pcpa_pkg::PAD_CONFIG_OFS, 8'h00);
      be <= 4'hF;
      settle();
      chk({31'h0, ttl}, 32'h1);
   endtask
   task automatic t_port_a();
      wr(pcpa_pkg::PIN_DATA_A_DATA_OFS, 8'h25);
      rchk(pcpa_pkg::PIN_DATA_A_LATCH_OFS, 8'h25);
      wr(pcpa_pkg::PIN_DATA_A_LATCH_OFS, 8'hFF);
      rchk(pcpa_pkg::PIN_DATA_A_LATCH_OFS, 8'hEF);
      wr(pcpa_pkg::PIN_DATA_A_DIR_OFS, 8'h0F);
      ext <= 8'h0A;
      settle();
      chk({16'h0, pa_oe, pa_o & pa_oe}, 32'hE0E0);
      rchk(pcpa_pkg::PIN_DATA_A_DATA_OFS, 8'hC0);
      wr(pcpa_pkg::ANALOG_CFG0_OFS, 8'h2F);
      settle();
      rchk(pcpa_pkg::PIN_DATA_A_DATA_OFS, 8'hEA);
      wr(pcpa_pkg::ANALOG_CTL_OFS, 8'h06);
      wr(pcpa_pkg::ANALOG_CFG0_OFS, 8'h00);
      settle();
      chk({28'h0, cmp1, cmp2}, 32'h9);
      wr(pcpa_pkg::PIN_DATA_A_DIR_OFS, 8'h00);
      settle();
      chk({24'h0, pa_oe}, 32'hEF);
      osc <= pcpa_pkg::OSC_CLKOUT;
      settle();
      chk({24'h0, pa_oe}, 32'hAF);
      osc <= pcpa_pkg::OSC_CRYSTAL;
      settle();
      chk({24'h0, pa_oe}, 32'h2F);
      osc <= pcpa_pkg::OSC_NONE;
      wr(pcpa_pkg::ANALOG_CFG0_OFS, 8'h2F);
      wr(pcpa_pkg::ANALOG_CTL_OFS, 8'h01);
      ext <= 8'h0E;
      settle();
      chk({24'h0, pa_oe}, 32'hEB);
      rchk(pcpa_pkg::PIN_DATA_A_DATA_OFS, 8'hEB);
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_reset();
      t_open_drain();
      t_clock_pad();
      t_port_a();
      report_and_stop();
   end
endmodule
